// [logic/rtc_alarm_consts.svh]
// Register offsets, field positions, reset values and counts of the clock
`ifndef RTC_ALARM_CONSTS_SVH
`define RTC_ALARM_CONSTS_SVH

// Register indexes on the plain register port
`define OFF_CLOCK_CONFIG 4'h0
`define OFF_CLOCK_TRIM 4'h1
`define OFF_PAD_CONFIG 4'h2
`define OFF_ALARM_CONFIG 4'h3
`define OFF_ALARM_REPEAT 4'h4
`define OFF_TIME_WIN_HIGH 4'h5
`define OFF_TIME_WIN_LOW 4'h6
`define OFF_ALARM_WIN_HIGH 4'h7
`define OFF_ALARM_WIN_LOW 4'h8

// Field positions
`define CFG_ENABLE_BIT 7
`define CFG_UNLOCK_BIT 5
`define CFG_ROLLOVER_BIT 4
`define CFG_HALF_BIT 3
`define CFG_PIN_OE_BIT 2
`define ACFG_ENABLE_BIT 7
`define ACFG_ENDLESS_BIT 6
`define PAD_SRC_LSB 1

// Reset value, and the value the endless repeat count wraps to
`define RESET_BYTE 8'h00
`define REPEAT_WRAP 8'hFF

// Oscillator ticks per half second, and the rollover warning window
`define PRESC_LAST 14'h3FFF
`define ROLLOVER_START 14'h3FE0

// BCD limits of the time fields
`define SEC_MAX 8'h59
`define HOUR_MAX 8'h23
`define WEEKDAY_MAX 8'h06
`define MONTH_MAX 8'h12
`define YEAR_MAX 8'h99
`define DAY_MIN 8'h01
`define DIGIT_MAX 4'h9

`endif

// [logic/rtc_alarm_pkg.sv]
// Types shared by the calendar clock alarm and trim logic
package rtc_alarm_pkg;

  typedef logic [7:0] bcd_t;

  typedef logic signed [10:0] trim_t;

  typedef enum logic [1:0]
  {
    SRC_ALARM_PULSE = 2'h0,
    SRC_SECONDS = 2'h1,
    SRC_SPARE2 = 2'h2,
    SRC_SPARE3 = 2'h3
  } pin_src_t;

  typedef enum logic [3:0]
  {
    IV_HALF_SEC = 4'h0,
    IV_SECOND = 4'h1,
    IV_TEN_SEC = 4'h2,
    IV_MINUTE = 4'h3,
    IV_TEN_MIN = 4'h4,
    IV_HOUR = 4'h5,
    IV_DAY = 4'h6,
    IV_WEEK = 4'h7,
    IV_MONTH = 4'h8,
    IV_YEAR = 4'h9
  } interval_t;

endpackage

// [logic/sync_two_ff.sv]
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff (
  input wire logic clk, // System clock
  input wire logic rst_n, // Power-on reset, active low
  input wire logic asyncIn, // Level from another domain
  output logic syncOut // Level safe to read
);
  logic meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end
endmodule // sync_two_ff
`default_nettype wire

// [logic/bcd_field.sv]
// One two-digit BCD time field with load and wrap to a minimum value
`timescale 1ns/1ns
`default_nettype none
module bcd_field #(
  parameter logic [7:0] MIN_VAL = 8'h00
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Power-on reset, active low
  input wire logic inc, // Count one step
  input wire logic load, // Software write, wins over inc
  input wire logic [7:0] loadVal, // Value written
  input wire logic [7:0] maxVal, // Last value before wrap
  output logic [7:0] value, // Field in BCD
  output logic carry // Wrap into next field
);
  // Lower digit carries at ten, not sixteen
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value <= MIN_VAL;
    else if (load)
      value <= loadVal;
    else if (inc)
    begin
      if (value == maxVal)
        value <= MIN_VAL;
      else if (value[3:0] >= 4'h9) // R24
        value <= {value[7:4] + 4'h1, 4'h0};
      else
        value <= value + 8'h01;
    end
  end

  assign carry = inc && !load && (value == maxVal);
endmodule // bcd_field
`default_nettype wire

// [logic/rtc_alarm_calibration.sv]
// Calendar clock with trim, masked alarm, repeat count and pin output
// Operation
// R1 - Negative trim removes oscillator pulses each minute
// R2 - Positive trim inserts extra pulses each minute
// R3 - Trim is signed byte times four
// R4 - Software writes trim when stopped or after second
// R5 - Alarm enable clears on event unless repeating
// R6 - Interval code selects which digits must match
// R7 - Match enabled digits each half second tick
// R8 - Zero count, no endless bit: one alarm
// R9 - Count FFh gives up to 255 repeats
// R10 - Count decrements per event, last at zero
// R11 - Final counted alarm clears the enable
// R12 - Endless mode wraps count to FF
// R13 - Every alarm event raises an interrupt
// R14 - Alarm pulse toggles per event, 50% duty
// R15 - Pin source 00 alarm, 01 seconds
// R16 - Runs in sleep; alarm wakes CPU
// R17 - Idle has no effect
// R18 - Device reset restores alarm configuration, clock runs
// R19 - Clock config and repeat reset only at power-on
// R20 - Prescalers cleared only by seconds write
// R21 - Software changes values only while alarm disabled
// R22 - Software edits alarm setup while rollover flag clear
// R23 - High alarm window access decrements pointer
// R24 - Time digits are BCD, carry at ten
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_consts.svh"
module rtc_alarm_calibration
  import rtc_alarm_pkg::*;
(
  input wire logic clk, // 250 MHz system clock
  input wire logic rst_n, // Power-on reset, async
  input wire logic devRst, // Device reset, sync, active high
  input wire logic xtalIn, // 32.768 kHz oscillator from pin
  input wire logic [3:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  output logic alarmIrq, // Interrupt pulse per alarm
  output logic wakeReq, // Wake request pulse per alarm
  output logic clkPin, // Clock output pin level
  output logic clkPinOe // Clock output pin enable
);
  logic xtalSync, xtalPrev_ff, oscTick;
  logic clkEn_ff, unlock_ff, pinOe_ff;
  logic [1:0] timePtr_ff, almPtr_ff;
  logic [7:0] trimCal_ff;
  pin_src_t pinSrc_ff;
  logic almEn_ff, endless_ff;
  interval_t almMask_ff;
  logic [7:0] almRpt_ff;
  bcd_t almVal_ff [0:5];
  logic [13:0] presc_ff;
  logic half_second_flag_ff, halfTickD_ff, almPulse_ff;
  trim_t trimPend_ff, trimLoadVal;
  logic trimPos, trimNeg, step, halfTick, secTick;
  logic secCarry, minCarry, hourCarry, dayCarry, monCarry;
  bcd_t tSec, tMin, tHour, tWday, tDay, tMon, tYear, dayMax;
  logic tLoHit, tHiHit, aHiAcc, timeWrLo, timeWrHi;
  logic acfgWr, rptWr, secLoad, match, alarmEvent, rollover;
  logic [2:0] almIdx;
  bcd_t timeWin, almWin;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Oscillator edges, synchronised before any logic looks at them
  sync_two_ff xtalSyncer (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(xtalIn),
    .syncOut(xtalSync)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      xtalPrev_ff <= 1'b0;
    else
      xtalPrev_ff <= xtalSync;
  end

  assign oscTick = xtalSync && !xtalPrev_ff;

  // Register strobes
  assign acfgWr = wr && (addr == `OFF_ALARM_CONFIG);
  assign rptWr = wr && (addr == `OFF_ALARM_REPEAT);
  assign tHiHit = (rd || wr) && (addr == `OFF_TIME_WIN_HIGH);
  assign aHiAcc = (rd || wr) && (addr == `OFF_ALARM_WIN_HIGH);
  assign tLoHit = wr && (addr == `OFF_TIME_WIN_LOW);
  assign timeWrLo = tLoHit && unlock_ff;
  assign timeWrHi = wr && (addr == `OFF_TIME_WIN_HIGH) && unlock_ff;
  assign secLoad = timeWrLo && (timePtr_ff == 2'h0);

  // Clock config: only power-on resets it, device reset keeps time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) // R19
    begin
      clkEn_ff <= 1'b0;
      unlock_ff <= 1'b0;
      pinOe_ff <= 1'b0;
      timePtr_ff <= 2'h0;
    end
    else if (wr && (addr == `OFF_CLOCK_CONFIG))
    begin
      clkEn_ff <= wdata[`CFG_ENABLE_BIT];
      unlock_ff <= wdata[`CFG_UNLOCK_BIT];
      pinOe_ff <= wdata[`CFG_PIN_OE_BIT];
      timePtr_ff <= wdata[1:0];
    end
    else if (tHiHit && (timePtr_ff != 2'h0))
      timePtr_ff <= timePtr_ff - 2'h1;
  end

  // Trim and pad config; trim is taken as written at any time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trimCal_ff <= `RESET_BYTE;
      pinSrc_ff <= SRC_ALARM_PULSE;
    end
    else if (wr && (addr == `OFF_CLOCK_TRIM))
      trimCal_ff <= wdata; // R4
    else if (wr && (addr == `OFF_PAD_CONFIG))
      pinSrc_ff <= pin_src_t'(wdata[`PAD_SRC_LSB +: 2]);
  end

  // Pending trim: positive inserts pulses, negative swallows ticks
  assign trimLoadVal = {trimCal_ff[7], trimCal_ff, 2'b00}; // R3
  assign trimPos = !trimPend_ff[10] && (trimPend_ff != 11'sh000);
  assign trimNeg = trimPend_ff[10];
  assign step = clkEn_ff && ((oscTick && !trimNeg) || trimPos); // R1 R2

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trimPend_ff <= 11'sh000;
    else if (secCarry) // Seconds field wraps once a minute
      trimPend_ff <= trimLoadVal; // R3
    else if (clkEn_ff && trimPos && !oscTick)
      trimPend_ff <= trimPend_ff - 11'sh001; // R2
    else if (clkEn_ff && trimNeg && oscTick)
      trimPend_ff <= trimPend_ff + 11'sh001; // R1
  end

  // Prescaler to half seconds; no device reset touches it
  assign halfTick = step && (presc_ff == `PRESC_LAST);
  assign secTick = halfTick && half_second_flag_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_ff <= 14'h0000;
      half_second_flag_ff <= 1'b0;
    end
    else if (secLoad) // R20
    begin
      presc_ff <= 14'h0000;
      half_second_flag_ff <= 1'b0;
    end
    else if (step)
    begin
      presc_ff <= presc_ff + 14'h0001;
      if (halfTick)
        half_second_flag_ff <= !half_second_flag_ff;
    end
  end

  // Month length with leap years every fourth year of the century
  always_comb
  begin
    logic leap;
    leap = tYear[4] ? (tYear[3:0] == 4'h2 || tYear[3:0] == 4'h6)
                    : (tYear[3:0] == 4'h0 || tYear[3:0] == 4'h4 ||
                       tYear[3:0] == 4'h8);
    unique case (tMon)
      8'h02: dayMax = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dayMax = 8'h30;
      default: dayMax = 8'h31;
    endcase
  end

  // Time fields in BCD; the seconds field carries into the rest
  bcd_field secField (.clk(clk), .rst_n(rst_n), .inc(secTick),
    .load(secLoad), .loadVal(wdata), .maxVal(`SEC_MAX),
    .value(tSec), .carry(secCarry));
  bcd_field minField (.clk(clk), .rst_n(rst_n), .inc(secCarry),
    .load(timeWrHi && timePtr_ff == 2'h0), .loadVal(wdata),
    .maxVal(`SEC_MAX), .value(tMin), .carry(minCarry));
  bcd_field hourField (.clk(clk), .rst_n(rst_n), .inc(minCarry),
    .load(timeWrLo && timePtr_ff == 2'h1), .loadVal(wdata),
    .maxVal(`HOUR_MAX), .value(tHour), .carry(hourCarry));
  bcd_field wdayField (.clk(clk), .rst_n(rst_n), .inc(hourCarry),
    .load(timeWrHi && timePtr_ff == 2'h1), .loadVal(wdata),
    .maxVal(`WEEKDAY_MAX), .value(tWday), .carry());
  bcd_field #(.MIN_VAL(`DAY_MIN)) dayField (.clk(clk), .rst_n(rst_n),
    .inc(hourCarry), .load(timeWrLo && timePtr_ff == 2'h2),
    .loadVal(wdata), .maxVal(dayMax), .value(tDay), .carry(dayCarry));
  bcd_field #(.MIN_VAL(`DAY_MIN)) monField (.clk(clk), .rst_n(rst_n),
    .inc(dayCarry), .load(timeWrHi && timePtr_ff == 2'h2),
    .loadVal(wdata), .maxVal(`MONTH_MAX), .value(tMon),
    .carry(monCarry));
  bcd_field yearField (.clk(clk), .rst_n(rst_n), .inc(monCarry),
    .load(timeWrLo && timePtr_ff == 2'h3), .loadVal(wdata),
    .maxVal(`YEAR_MAX), .value(tYear), .carry());

  // Alarm config: device reset disables the alarm
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      almEn_ff <= 1'b0;
      endless_ff <= 1'b0;
      almMask_ff <= IV_HALF_SEC;
      almPtr_ff <= 2'h0;
    end
    else if (devRst) // R18
    begin
      almEn_ff <= 1'b0;
      endless_ff <= 1'b0;
      almMask_ff <= IV_HALF_SEC;
      almPtr_ff <= 2'h0;
    end
    else if (acfgWr)
    begin
      almEn_ff <= wdata[`ACFG_ENABLE_BIT];
      endless_ff <= wdata[`ACFG_ENDLESS_BIT];
      almMask_ff <= interval_t'(wdata[5:2]);
      almPtr_ff <= wdata[1:0];
    end
    else
    begin
      if (alarmEvent && !endless_ff && almRpt_ff == 8'h00)
        almEn_ff <= 1'b0; // R5 R8 R11
      if (aHiAcc && almPtr_ff != 2'h0)
        almPtr_ff <= almPtr_ff - 2'h1; // R23
    end
  end

  // Repeat count survives device reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) // R19
      almRpt_ff <= `RESET_BYTE;
    else if (rptWr)
      almRpt_ff <= wdata; // R9
    else if (alarmEvent)
    begin
      if (almRpt_ff != 8'h00)
        almRpt_ff <= almRpt_ff - 8'h01; // R10
      else if (endless_ff)
        almRpt_ff <= `REPEAT_WRAP; // R12
    end
  end

  // Alarm values: index is pointer times two plus the high half
  assign almIdx = {almPtr_ff, addr == `OFF_ALARM_WIN_HIGH};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 6; i++)
        almVal_ff[i] <= `RESET_BYTE;
    end
    else if (wr && almPtr_ff != 2'h3 &&
             (addr == `OFF_ALARM_WIN_HIGH || addr == `OFF_ALARM_WIN_LOW))
      almVal_ff[almIdx] <= wdata;
  end

  // Compare one cycle after the tick so the fields have settled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      halfTickD_ff <= 1'b0;
    else
      halfTickD_ff <= halfTick;
  end

  // Masked digit compare; whole-second codes fire only at second start
  always_comb
  begin
    logic s, m;
    s = (tSec == almVal_ff[0]);
    m = (tMin == almVal_ff[1]);
    unique case (almMask_ff) // R6
      IV_HALF_SEC: match = 1'b1;
      IV_SECOND: match = !half_second_flag_ff;
      IV_TEN_SEC: match = !half_second_flag_ff && tSec[3:0] == almVal_ff[0][3:0];
      IV_MINUTE: match = !half_second_flag_ff && s;
      IV_TEN_MIN:
        match = !half_second_flag_ff && s && tMin[3:0] == almVal_ff[1][3:0];
      IV_HOUR: match = !half_second_flag_ff && s && m;
      IV_DAY: match = !half_second_flag_ff && s && m && tHour == almVal_ff[2];
      IV_WEEK: match = !half_second_flag_ff && s && m && tHour == almVal_ff[2] &&
                       tWday == almVal_ff[3];
      IV_MONTH: match = !half_second_flag_ff && s && m && tHour == almVal_ff[2] &&
                        tDay == almVal_ff[4];
      IV_YEAR: match = !half_second_flag_ff && s && m && tHour == almVal_ff[2] &&
                       tDay == almVal_ff[4] && tMon == almVal_ff[5];
      default: match = 1'b0;
    endcase
  end

  // Runs in every power mode, so an event can always wake the CPU
  assign alarmEvent = halfTickD_ff && almEn_ff && match; // R7 R16 R17

  // Interrupt, wake and alarm pulse outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarmIrq <= 1'b0;
      wakeReq <= 1'b0;
      almPulse_ff <= 1'b0;
    end
    else
    begin
      alarmIrq <= alarmEvent; // R13
      wakeReq <= alarmEvent; // R16
      if (alarmEvent)
        almPulse_ff <= !almPulse_ff; // R14
    end
  end

  // Pin driver; spare source codes hold the pin low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkPin <= 1'b0;
      clkPinOe <= 1'b0;
    end
    else
    begin
      clkPinOe <= pinOe_ff && clkEn_ff;
      unique case (pinSrc_ff) // R15
        SRC_ALARM_PULSE: clkPin <= almPulse_ff;
        SRC_SECONDS: clkPin <= half_second_flag_ff;
        default: clkPin <= 1'b0;
      endcase
    end
  end

  // Warns software of a coming rollover
  assign rollover = clkEn_ff && half_second_flag_ff && presc_ff >= `ROLLOVER_START;

  // Window read multiplexers
  always_comb
  begin
    unique case ({timePtr_ff, addr == `OFF_TIME_WIN_HIGH})
      3'h0: timeWin = tSec;
      3'h1: timeWin = tMin;
      3'h2: timeWin = tHour;
      3'h3: timeWin = tWday;
      3'h4: timeWin = tDay;
      3'h5: timeWin = tMon;
      3'h6: timeWin = tYear;
      default: timeWin = 8'h00;
    endcase
    almWin = (almPtr_ff == 2'h3) ? 8'h00 : almVal_ff[almIdx];
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (!rd)
      rdata <= 8'h00;
    else
    begin
      unique case (addr)
        `OFF_CLOCK_CONFIG: rdata <= {clkEn_ff, 1'b0, unlock_ff, rollover,
                                     half_second_flag_ff, pinOe_ff, timePtr_ff};
        `OFF_CLOCK_TRIM: rdata <= trimCal_ff;
        `OFF_PAD_CONFIG: rdata <= {5'h00, pinSrc_ff, 1'b0};
        `OFF_ALARM_CONFIG: rdata <= {almEn_ff, endless_ff, almMask_ff,
                                     almPtr_ff};
        `OFF_ALARM_REPEAT: rdata <= almRpt_ff;
        `OFF_TIME_WIN_HIGH, `OFF_TIME_WIN_LOW: rdata <= timeWin;
        `OFF_ALARM_WIN_HIGH, `OFF_ALARM_WIN_LOW: rdata <= almWin;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  sequence hiWinAccess;
    aHiAcc && almPtr_ff != 2'h0 && !acfgWr && !devRst;
  endsequence
  sequence lastAlarm;
    alarmEvent && !endless_ff && almRpt_ff == 8'h00 && !acfgWr && !devRst;
  endsequence

  trimLoad_a: assert property (secCarry |=> // R3
    trimPend_ff == $past(trimLoadVal))
    else $error("trim not loaded as four times the trim byte");
  trimInsert_a: assert property ( // R2
    clkEn_ff && trimPos && !oscTick && !secCarry |->
    step ##1 trimPend_ff == $past(trimPend_ff) - 11'sh001)
    else $error("positive trim did not insert a pulse");
  trimRemove_a: assert property ( // R1
    clkEn_ff && trimNeg && oscTick |-> !step)
    else $error("negative trim did not remove a tick");
  oneShot_a: assert property (lastAlarm |=> !almEn_ff) // R8 R11
    else $error("alarm enable not cleared after last alarm");
  keepEnable_a: assert property ( // R5
    alarmEvent && (endless_ff || almRpt_ff != 8'h00) && !acfgWr &&
    !devRst |=> almEn_ff)
    else $error("alarm enable cleared while repeating");
  repeatDown_a: assert property ( // R10
    alarmEvent && almRpt_ff != 8'h00 && !rptWr |=>
    almRpt_ff == $past(almRpt_ff) - 8'h01)
    else $error("repeat count not decremented");
  endlessWrap_a: assert property ( // R12
    alarmEvent && endless_ff && almRpt_ff == 8'h00 && !rptWr |=>
    almRpt_ff == `REPEAT_WRAP)
    else $error("endless count did not wrap");
  irqPulse_a: assert property (alarmEvent |=> // R13
    alarmIrq && wakeReq ##1 !alarmIrq || $past(alarmEvent, 1))
    else $error("alarm interrupt not raised");
  pulseFlip_a: assert property (alarmEvent |=> // R14
    almPulse_ff != $past(almPulse_ff))
    else $error("alarm pulse did not toggle");
  pinSeconds_a: assert property ( // R15
    pinSrc_ff == SRC_SECONDS |=> clkPin == $past(half_second_flag_ff))
    else $error("pin does not show the seconds clock");
  ptrDown_a: assert property (hiWinAccess |=> // R23
    almPtr_ff == $past(almPtr_ff) - 2'h1)
    else $error("alarm pointer not decremented");
  devReset_a: assert property (devRst |=> // R18
    !almEn_ff && almMask_ff == IV_HALF_SEC)
    else $error("device reset left alarm configured");
  secWrite_a: assert property (secLoad |=> // R20
    presc_ff == 14'h0000 && !half_second_flag_ff)
    else $error("seconds write did not clear prescaler");
  bcdDigit_a: assert property (tSec[3:0] <= `DIGIT_MAX) // R24
    else $error("seconds digit left BCD range");
endmodule // rtc_alarm_calibration
`default_nettype wire

// [dv/xtal_model.sv]
// Free-running crystal stand-in that feeds the oscillator pin
`timescale 1ns/1ns
`default_nettype none
module xtal_model #(
  parameter int HALF = 1
) (
  input wire logic clk, // System clock
  output logic osc // Oscillator pin level
);
  int cnt = 0;
  // Runs far faster than a real crystal so a half second fits the run
  always @(posedge clk)
  begin
    if (cnt >= HALF - 1)
    begin
      cnt <= 0;
      osc <= ~osc;
    end
    else
      cnt <= cnt + 1;
  end
  initial
    osc = 1'b0;
endmodule // xtal_model
`default_nettype wire

// [dv/rtc_alarm_calibration_tb.sv]
// Self-checking bench for the calendar clock alarm, trim and pin logic
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_consts.svh"
module rtc_alarm_calibration_tb
  import rtc_alarm_pkg::*;
;
  logic clk, rst_n, devRst, xtalIn, wr, rd, alarmIrq, wakeReq;
  logic clkPin, clkPinOe, enExp, endlessExp;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, trim;
  logic [7:0] alm [0:5];
  int failCount, totalChecks, alarmPtr, repExp, pulseExp;

  xtal_model #(.HALF(1)) XT (.clk(clk), .osc(xtalIn));
  rtc_alarm_calibration DUT (.clk(clk), .rst_n(rst_n), .devRst(devRst),
    .xtalIn(xtalIn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .alarmIrq(alarmIrq), .wakeReq(wakeReq),
    .clkPin(clkPin), .clkPinOe(clkPinOe));

  // 250 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s,
    input logic [7:0] e);
    totalChecks++;
    if (s !== e)
    begin
      failCount++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  // One-cycle strobes, changed just after the edge
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rchk(input string n, input logic [3:0] a,
    input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask

  // Alarm window access against the pointer model; slot 3 holds nothing
  task automatic awin(input logic hi, input logic wrt);
    logic [7:0] d;
    int i;
    d = 8'($urandom);
    i = alarmPtr * 2 + int'(hi);
    if (wrt)
    begin
      wreg(hi ? `OFF_ALARM_WIN_HIGH : `OFF_ALARM_WIN_LOW, d);
      if (alarmPtr < 3)
        alm[i] = d;
    end
    else
      rchk("alarm window", hi ? `OFF_ALARM_WIN_HIGH : `OFF_ALARM_WIN_LOW,
        alarmPtr < 3 ? alm[i] : 8'h00);
    if (hi && alarmPtr > 0)
      alarmPtr--;
  endtask

  // Wait for one alarm event, then update and compare the model
  task automatic evt(input logic [6:0] lo);
    int n;
    n = 0;
    #1;
    while (alarmIrq !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("irq", {7'h0, alarmIrq}, 8'h01);
    chk("wake", {7'h0, wakeReq}, 8'h01);
    if (repExp != 0)
      repExp--;
    else if (endlessExp)
      repExp = 255;
    else
      enExp = 1'b0;
    pulseExp = 1 - pulseExp;
    @(posedge clk);
    #1 chk("irq width", {7'h0, alarmIrq}, 8'h00);
    chk("pulse pin", {7'h0, clkPin}, 8'(pulseExp));
    rchk("repeat", `OFF_ALARM_REPEAT, 8'(repExp));
    rchk("alarm cfg", `OFF_ALARM_CONFIG, {enExp, lo});
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    devRst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    failCount = 0;
    totalChecks = 0;
    repExp = 0;
    pulseExp = 0;
    enExp = 1'b0;
    endlessExp = 1'b0;
    void'($urandom(50));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++)
      rchk("reset value", 4'(a), 8'h00);
    chk("pin oe idle", {7'h0, clkPinOe}, 8'h00);
    trim = 8'($urandom);
    wreg(`OFF_CLOCK_TRIM, trim);
    rchk("trim", `OFF_CLOCK_TRIM, trim);
    wreg(`OFF_PAD_CONFIG, 8'h04);
    rchk("pad", `OFF_PAD_CONFIG, 8'h04);
    wreg(`OFF_PAD_CONFIG, 8'h00);
    // Alarm values are loaded while the alarm is off
    alarmPtr = 3;
    wreg(`OFF_ALARM_CONFIG, 8'h03);
    repeat (4)
    begin
      awin(1'b0, 1'b1);
      awin(1'b1, 1'b1);
    end
    alarmPtr = 3;
    wreg(`OFF_ALARM_CONFIG, 8'h03);
    repeat (4)
    begin
      awin(1'b0, 1'b0);
      awin(1'b1, 1'b0);
    end
    rchk("ptr end", `OFF_ALARM_CONFIG, 8'h00);
    // Status bits ignore writes and bit 6 reads zero
    wreg(`OFF_CLOCK_CONFIG, 8'hFF);
    rchk("clk cfg", `OFF_CLOCK_CONFIG, 8'hA7);
    chk("pin oe", {7'h0, clkPinOe}, 8'h01);
    wreg(`OFF_CLOCK_CONFIG, 8'hA4);
    wreg(`OFF_TIME_WIN_LOW, 8'h59);
    wreg(`OFF_ALARM_REPEAT, 8'h01);
    repExp = 1;
    wreg(`OFF_ALARM_CONFIG, 8'h80);
    enExp = 1'b1;
    evt(7'h00);
    // Hourly alarm at minute 01 second 00, set up with the alarm off
    wreg(`OFF_ALARM_CONFIG, 8'h00);
    wreg(`OFF_ALARM_WIN_LOW, 8'h00);
    wreg(`OFF_ALARM_WIN_HIGH, 8'h01);
    wreg(`OFF_ALARM_CONFIG, 8'h94);
    evt(7'h14);
    rchk("minute", `OFF_TIME_WIN_HIGH, 8'h01);
    rchk("second", `OFF_TIME_WIN_LOW, 8'h00);
    rchk("whole sec", `OFF_CLOCK_CONFIG, 8'hA4);
    wreg(`OFF_ALARM_CONFIG, 8'hC0);
    enExp = 1'b1;
    endlessExp = 1'b1;
    evt(7'h40);
    // Seconds clock source shows the half flag, high after this event
    wreg(`OFF_PAD_CONFIG, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk("pin seconds", {7'h0, clkPin}, 8'h01);
    // Unused pin sources drive low even with the pulse high
    wreg(`OFF_PAD_CONFIG, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk("pin src 2", {7'h0, clkPin}, 8'h00);
    @(posedge clk);
    devRst <= 1'b1;
    @(posedge clk);
    devRst <= 1'b0;
    rchk("cfg dev rst", `OFF_ALARM_CONFIG, 8'h00);
    rchk("rep dev rst", `OFF_ALARM_REPEAT, 8'hFF);
    rchk("clk dev rst", `OFF_CLOCK_CONFIG, 8'hAC);
    rchk("trim dev rst", `OFF_CLOCK_TRIM, trim);
    conclude();
  end

  // Three half seconds take about 400 us
  initial
  begin
    #420000;
    failCount++;
    conclude();
  end
endmodule // rtc_alarm_calibration_tb
`default_nettype wire
